// ==== tmr_evgen_pkg.sv ====
package tmr_evgen_pkg;

    // Widths and channel count
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int NUM_CH = 4;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHMODE = 8'h04;
    localparam logic [7:0] OFS_DMAEN = 8'h08;
    localparam logic [7:0] OFS_INTMASK = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_EVGEN = 8'h14;
    localparam logic [7:0] OFS_RELOAD = 8'h2c;
    localparam logic [7:0] OFS_CAPT0 = 8'h34;
    localparam logic [7:0] OFS_CAPT_STEP = 8'h04;

    // Event register, status and mask share this bit layout
    localparam int BIT_UPD = 0;
    localparam int BIT_CH1 = 1;
    localparam int BIT_TRG = 6;
    localparam int BIT_RPT1 = 9;

    // Control register fields
    localparam int CTRL_UPD_DIS = 0;
    localparam int CTRL_UPD_SRC = 1;
    localparam int CTRL_DOWN = 4;
    localparam int CTRL_CENTER = 5;

    // Values after reset
    localparam logic [15:0] RST_EVGEN = 16'h0000;
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_CHMODE = 16'h0000;
    localparam logic [15:0] RST_DMAEN = 16'h0000;
    localparam logic [15:0] RST_INTMASK = 16'h0000;
    localparam logic [15:0] RST_RELOAD = 16'h0000;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    // Self-clearing software force pulses
    typedef struct packed {
        logic update;
        logic [NUM_CH-1:0] ch;
        logic trigger;
    } force_t;

    // Commands towards the counter engine and prescaler
    typedef struct packed {
        logic load;
        logic [DATA_W-1:0] load_value;
        logic presc_clear;
        logic update;
        logic trigger;
    } timer_ctl_t;

    // State of one capture/compare channel
    typedef struct packed {
        logic [DATA_W-1:0] capture;
        logic flag;
        logic repeat_flag;
        logic dma_req;
    } ch_state_t;

    // State of the register block
    typedef struct packed {
        logic [DATA_W-1:0] ctrl;
        logic [DATA_W-1:0] chmode;
        logic [DATA_W-1:0] dmaen;
        logic [DATA_W-1:0] mask;
        logic [DATA_W-1:0] reload;
        logic [DATA_W-1:0] rdata;
        logic upd_flag;
        logic trg_flag;
        timer_ctl_t ctl;
    } main_state_t;

endpackage

// ==== evgen_strobe.sv ====
module evgen_strobe
    import tmr_evgen_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic wr_in,
    input wire logic sel_in,
    input wire logic [DATA_W-1:0] wdata_in,
    output force_t force_out
);
    force_t force_reg;
    force_t force_next;

    // Bits live for one enabled cycle only; the event register always reads as zero
    always_comb begin
        force_next = RST_EVGEN[$bits(force_t)-1:0];
        if (wr_in && sel_in) begin
            force_next.update = wdata_in[BIT_UPD];
            force_next.ch = wdata_in[BIT_CH1 +: NUM_CH];
            force_next.trigger = wdata_in[BIT_TRG];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            force_reg <= RST_EVGEN[$bits(force_t)-1:0];
        end else if (ce_in) begin
            force_reg <= force_next;
        end
    end

    assign force_out = force_reg;
endmodule // evgen_strobe

// ==== capture_channel.sv ====
module capture_channel
    import tmr_evgen_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic fire_in,
    input wire logic input_mode_in,
    input wire logic [DATA_W-1:0] count_in,
    input wire logic clr_flag_in,
    input wire logic clr_repeat_in,
    input wire logic dma_en_in,
    output ch_state_t state_out
);
    ch_state_t s_reg;
    ch_state_t s_next;

    // Set wins over a clear in the same cycle
    always_comb begin
        s_next = s_reg;
        s_next.dma_req = 1'b0;
        if (clr_flag_in) begin
            s_next.flag = 1'b0;
        end
        if (clr_repeat_in) begin
            s_next.repeat_flag = 1'b0;
        end
        if (fire_in) begin
            s_next.flag = 1'b1;
            s_next.dma_req = dma_en_in;
            if (input_mode_in) begin
                s_next.capture = count_in;
                if (s_reg.flag) begin
                    s_next.repeat_flag = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_reg <= '0;
        end else if (ce_in) begin
            s_reg <= s_next;
        end
    end

    assign state_out = s_reg;
endmodule // capture_channel

// ==== timer_event_gen.sv ====
module timer_event_gen
    import tmr_evgen_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    input wire logic [DATA_W-1:0] count_in,
    input wire logic hw_trigger_in,
    output timer_ctl_t ctl_out,
    output logic [NUM_CH-1:0] dma_req_out,
    output logic irq_out
);
    main_state_t s_reg;
    main_state_t s_next;
    force_t force_pulse;
    ch_state_t [NUM_CH-1:0] ch_state;
    logic [NUM_CH-1:0] ch_flag;
    logic [NUM_CH-1:0] ch_repeat;
    logic [NUM_CH-1:0] ch_clr_flag;
    logic [NUM_CH-1:0] ch_capt_read;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] status_clr;
    logic wr_evgen;

    assign wr_evgen = wr_in && (addr_in == OFS_EVGEN);

    // Self-clearing force register
    evgen_strobe u_strobe (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .wr_in(wr_in),
        .sel_in(wr_evgen),
        .wdata_in(wdata_in),
        .force_out(force_pulse)
    );

    // Write-one-to-clear mask for the status register
    assign status_clr = (wr_in && (addr_in == OFS_STATUS)) ? wdata_in : '0;

    // One channel slice per capture/compare channel
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            // Reading a capture register in input mode also clears that flag
            assign ch_capt_read[gi] = rd_in && s_reg.chmode[gi] &&
                (addr_in == OFS_CAPT0 + 8'(gi) * OFS_CAPT_STEP);
            assign ch_clr_flag[gi] = status_clr[BIT_CH1 + gi] ||
                ch_capt_read[gi];
            capture_channel u_ch (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .ce_in(ce_in),
                .fire_in(force_pulse.ch[gi]),
                .input_mode_in(s_reg.chmode[gi]),
                .count_in(count_in),
                .clr_flag_in(ch_clr_flag[gi]),
                .clr_repeat_in(status_clr[BIT_RPT1 + gi]),
                .dma_en_in(s_reg.dmaen[BIT_CH1 + gi]),
                .state_out(ch_state[gi])
            );
            assign ch_flag[gi] = ch_state[gi].flag;
            assign ch_repeat[gi] = ch_state[gi].repeat_flag;
            assign dma_req_out[gi] = ch_state[gi].dma_req;
        end
    endgenerate

    // Status image in the shared event bit layout
    always_comb begin
        status = '0;
        status[BIT_UPD] = s_reg.upd_flag;
        status[BIT_CH1 +: NUM_CH] = ch_flag;
        status[BIT_TRG] = s_reg.trg_flag;
        status[BIT_RPT1 +: NUM_CH] = ch_repeat;
    end

    // Level interrupt while any unmasked flag stands
    assign irq_out = |(status & s_reg.mask);

    // Register writes, forced events and read mux
    always_comb begin
        s_next = s_reg;
        s_next.ctl.load = 1'b0;
        s_next.ctl.presc_clear = 1'b0;
        s_next.ctl.update = 1'b0;
        s_next.ctl.trigger = 1'b0;
        s_next.rdata = '0;
        if (wr_in) begin
            case (addr_in)
                OFS_CTRL: s_next.ctrl = wdata_in;
                OFS_CHMODE: s_next.chmode = wdata_in & 16'h000f;
                OFS_DMAEN: s_next.dmaen = wdata_in;
                OFS_INTMASK: s_next.mask = wdata_in;
                OFS_RELOAD: s_next.reload = wdata_in;
                default: ;
            endcase
        end
        // Software clears first so a same-cycle set still wins
        if (status_clr[BIT_UPD]) begin
            s_next.upd_flag = 1'b0;
        end
        if (status_clr[BIT_TRG]) begin
            s_next.trg_flag = 1'b0;
        end
        if (force_pulse.update) begin
            s_next.ctl.load = 1'b1;
            s_next.ctl.presc_clear = 1'b1;
            // Center mode counts up first, so it also starts at zero
            if (s_reg.ctrl[CTRL_DOWN] && !s_reg.ctrl[CTRL_CENTER]) begin
                s_next.ctl.load_value = s_reg.reload;
            end else begin
                s_next.ctl.load_value = COUNT_ZERO;
            end
            s_next.ctl.update = !s_reg.ctrl[CTRL_UPD_DIS];
            if (!s_reg.ctrl[CTRL_UPD_SRC] && !s_reg.ctrl[CTRL_UPD_DIS]) begin
                s_next.upd_flag = 1'b1;
            end
        end
        if (force_pulse.trigger || hw_trigger_in) begin
            s_next.ctl.trigger = 1'b1;
            s_next.trg_flag = 1'b1;
        end
        if (rd_in) begin
            case (addr_in)
                OFS_CTRL: s_next.rdata = s_reg.ctrl;
                OFS_CHMODE: s_next.rdata = s_reg.chmode;
                OFS_DMAEN: s_next.rdata = s_reg.dmaen;
                OFS_INTMASK: s_next.rdata = s_reg.mask;
                OFS_STATUS: s_next.rdata = status;
                OFS_RELOAD: s_next.rdata = s_reg.reload;
                OFS_EVGEN: s_next.rdata = '0;
                default: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (addr_in == OFS_CAPT0 + 8'(i) * OFS_CAPT_STEP) begin
                            s_next.rdata = ch_state[i].capture;
                        end
                    end
                end
            endcase
        end
    end

    // Clock enable freezes everything, including pulses
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_reg.ctrl <= RST_CTRL;
            s_reg.chmode <= RST_CHMODE;
            s_reg.dmaen <= RST_DMAEN;
            s_reg.mask <= RST_INTMASK;
            s_reg.reload <= RST_RELOAD;
            s_reg.rdata <= '0;
            s_reg.upd_flag <= 1'b0;
            s_reg.trg_flag <= 1'b0;
            s_reg.ctl <= '0;
        end else if (ce_in) begin
            s_reg <= s_next;
        end
    end

    assign rdata_out = s_reg.rdata;
    assign ctl_out = s_reg.ctl;
endmodule // timer_event_gen

// ==== timer_event_gen_assertions.sv ====
module timer_event_gen_checker
    import tmr_evgen_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic [DATA_W-1:0] count_in,
    input wire logic hw_trigger_in,
    input wire timer_ctl_t ctl_out,
    input wire logic [NUM_CH-1:0] dma_req_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // Event register write while running
    logic ev;
    assign ev = ce_in && wr_in && addr_in == OFS_EVGEN;

    upd_load_a: assert property (ev && wdata_in[BIT_UPD]
        ##1 ce_in ##1 ce_in |-> ctl_out.load && ctl_out.presc_clear)
        else $error("no load after update write");
    upd_clear_a: assert property (ev && wdata_in[BIT_UPD]
        ##1 (ce_in && !wr_in)[*2] ##1 ce_in |-> !ctl_out.load)
        else $error("load pulse did not end");
    trg_pulse_a: assert property (ev && wdata_in[BIT_TRG]
        ##1 ce_in ##1 ce_in |-> ctl_out.trigger)
        else $error("no trigger after trigger write");
    hw_trg_a: assert property (ce_in && hw_trigger_in ##1 ce_in
        |-> ctl_out.trigger)
        else $error("hardware trigger lost");
    // Zero bits must stay silent; a hardware trigger would mask it
    zero_write_a: assert property (ev && wdata_in[6:0] == 7'h00
        ##1 (ce_in && !wr_in && !hw_trigger_in) ##1 (ce_in && !wr_in)
        |-> !ctl_out.load && !ctl_out.trigger && dma_req_out == 4'h0)
        else $error("zero write made an event");
    evgen_read_a: assert property (ce_in && rd_in
        && addr_in == OFS_EVGEN |=> rdata_out == 16'h0000)
        else $error("event register read not zero");
    dma_src_a: assert property (dma_req_out != 4'h0
        |-> $past(wr_in, 2) && $past(addr_in, 2) == OFS_EVGEN)
        else $error("dma request without forced event");
    upd_pair_a: assert property (ctl_out.update
        |-> ctl_out.load && ctl_out.presc_clear)
        else $error("update without reinit");

    cover property (ctl_out.load && ctl_out.load_value != 16'h0000);
    cover property (dma_req_out != 4'h0);
    cover property (irq_out && ctl_out.trigger);
endmodule // timer_event_gen_checker

bind timer_event_gen timer_event_gen_checker i_timer_event_gen_checker (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .count_in(count_in),
    .hw_trigger_in(hw_trigger_in), .ctl_out(ctl_out),
    .dma_req_out(dma_req_out), .irq_out(irq_out));

// ==== test_timer_software_event_generation.sv ====
module test_timer_software_event_generation
    import tmr_evgen_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, rst_b_in = 0, ce_in = 1, wr_in = 0, rd_in = 0;
    logic hw_trigger_in = 0, irq_out;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000, count_in = 16'h0000;
    logic [15:0] rdata_out, rd_val;
    logic [3:0] dma_req_out;
    timer_ctl_t ctl_out;
    int mismatches = 0, samples_checked = 0, cycles = 0;

    timer_event_gen i_timer_event_gen (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .count_in(count_in),
        .hw_trigger_in(hw_trigger_in), .ctl_out(ctl_out),
        .dma_req_out(dma_req_out), .irq_out(irq_out));

    // 20 MHz clock and a hang guard well above the run length
    initial forever #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end

    task conclude;
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Bus cycles: strobe for one edge, read data only in the next cycle
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 rd_val = rdata_out;
    endtask
    // Outputs of a forced event stand one cycle, after the next edge
    task fire(input logic [15:0] d);
        wr(OFS_EVGEN, d);
        @(posedge clk_in);
        #1;
    endtask
    task pulses(input logic [15:0] exp);
        chk({10'h0, ctl_out.load, ctl_out.trigger, dma_req_out}, exp);
    endtask

    task t_update;
        logic [15:0] ctrl [6] = '{16'h0, 16'h10, 16'h30, 16'h20, 16'h2, 16'h1};
        logic [15:0] lv [6] = '{16'h0, 16'h1234, 16'h0, 16'h0, 16'h0, 16'h0};
        logic [1:0] uf [6] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h0};
        rd(OFS_EVGEN);
        chk(rd_val, RST_EVGEN);
        rd(8'hfc);
        chk(rd_val, 16'h0000);
        wr(OFS_RELOAD, 16'h1234);
        wr(OFS_INTMASK, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            wr(OFS_CTRL, ctrl[i]);
            fire(16'h0001);
            chk({14'h0, ctl_out.load, ctl_out.presc_clear}, 16'h3);
            chk(ctl_out.load_value, lv[i]);
            chk({15'h0, ctl_out.update}, {15'h0, uf[i][1]});
            @(posedge clk_in);
            #1 pulses(16'h0000);
            rd(OFS_STATUS);
            chk(rd_val, {15'h0, uf[i][0]});
            chk({15'h0, irq_out}, {15'h0, uf[i][0]});
            wr(OFS_STATUS, 16'hffff);
        end
        wr(OFS_CTRL, 16'h0000);
    endtask

    // Input mode twice per channel, then channel 1 in output mode
    task t_channels;
        wr(OFS_CHMODE, 16'h000f);
        wr(OFS_DMAEN, 16'h001e);
        wr(OFS_INTMASK, 16'h001e);
        for (int n = 1; n <= 4; n++) begin
            @(posedge clk_in);
            count_in <= 16'h0a00 + 16'(n);
            fire(16'h0001 << n);
            pulses(16'h0001 << (n - 1));
            chk({15'h0, irq_out}, 16'h0001);
            fire(16'h0001 << n);
            rd(OFS_STATUS);
            chk(rd_val, 16'h0101 << n);
            rd(OFS_CAPT0 + 8'(4 * (n - 1)));
            chk(rd_val, 16'h0a00 + 16'(n));
            wr(OFS_STATUS, 16'hffff);
        end
        wr(OFS_CHMODE, 16'h0000);
        count_in <= 16'h5555;
        fire(16'h0002);
        fire(16'h0002);
        pulses(16'h0001);
        rd(OFS_STATUS);
        chk(rd_val, 16'h0002);
        chk({15'h0, irq_out}, 16'h0001);
        rd(OFS_CAPT0);
        chk(rd_val, 16'h0a01);
        wr(OFS_STATUS, 16'hffff);
    endtask

    task t_trigger;
        wr(OFS_INTMASK, 16'h0040);
        wr(OFS_EVGEN, 16'h0040);
        @(posedge clk_in);
        ce_in <= 1'b0;
        #1 pulses(16'h0010);
        chk({15'h0, irq_out}, 16'h0001);
        // A low clock enable freezes the pulse for one more cycle
        @(posedge clk_in);
        ce_in <= 1'b1;
        #1 pulses(16'h0010);
        @(posedge clk_in);
        #1 pulses(16'h0000);
        wr(OFS_STATUS, 16'h0040);
        #1 chk({15'h0, irq_out}, 16'h0000);
        @(posedge clk_in);
        hw_trigger_in <= 1'b1;
        @(posedge clk_in);
        hw_trigger_in <= 1'b0;
        #1 pulses(16'h0010);
        wr(OFS_STATUS, 16'hffff);
        fire(16'hff20);
        pulses(16'h0000);
        rd(OFS_STATUS);
        chk(rd_val, 16'h0000);
    endtask

    initial begin
        repeat (8) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_update();
        t_channels();
        t_trigger();
        conclude();
    end
endmodule // test_timer_software_event_generation
